/* twm_pkg.sv */
// shared constants for the two-wire memory and clock access ends
package twm_pkg;

	// selection byte layout
	localparam logic [3:0]  MEM_ID       = 4'ha;
	localparam logic [3:0]  RTC_ID       = 4'hd;
	localparam int unsigned SEL_ID_MSB   = 7;
	localparam int unsigned SEL_ID_LSB   = 4;
	localparam int unsigned SEL_CS_MSB   = 3;
	localparam int unsigned SEL_CS_LSB   = 1;
	localparam int unsigned SEL_RW_BIT   = 0;

	// address latches
	localparam int unsigned MEM_AW       = 15;
	localparam int unsigned MEM_WORDS    = 32768;
	localparam int unsigned RTC_AW       = 4;
	localparam logic [14:0] MEM_ADDR_RST = 15'h0000;
	localparam logic [3:0]  RTC_ADDR_RST = 4'h0;

	// bit counting within a byte
	localparam logic [3:0]  BITS_DATA    = 4'h8;
	localparam logic [3:0]  BIT_ACK      = 4'h9;

	// bus clock made by the master end
	localparam int unsigned MCLK_NS      = 50;
	localparam int unsigned SCL_PERIOD_NS = 1000;
	localparam int unsigned QUARTERS     = 4;
	localparam int unsigned SCL_QTR_CYC  =
		(SCL_PERIOD_NS / QUARTERS + MCLK_NS - 1) / MCLK_NS;

	// selection byte builder
	function automatic logic [7:0] sel_byte(input logic       rtc,
	                                        input logic [2:0] cs,
	                                        input logic       rd);
		sel_byte = {(rtc ? RTC_ID : MEM_ID), cs, rd};
	endfunction : sel_byte

endpackage : twm_pkg

/* twm_link_if.sv */
// two-wire link between master end and device end
`timescale 1ns/10ps
`default_nettype none
interface twm_link_if;
	logic scl;
	logic sda;
	logic mst_sda_out;
	logic mst_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;

	// open-drain wired level with pull-up
	assign sda = ~((~mst_sda_oe_n & ~mst_sda_out)
	             | (~dev_sda_oe_n & ~dev_sda_out));

	modport mst (output scl, output mst_sda_out, output mst_sda_oe_n,
	             input sda);
	modport dev (input scl, input sda, output dev_sda_out,
	             output dev_sda_oe_n);
endinterface : twm_link_if
`default_nettype wire

/* twm_mst.sv */
// two-wire bus master end: makes the bus clock and runs transfers
`timescale 1ns/10ps
`default_nettype none
module twm_mst #(
	parameter int unsigned SCL_DIV = twm_pkg::SCL_QTR_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	twm_link_if.mst          link_io,
	input  wire logic        cmd_valid_in,
	output logic             cmd_ready_out,
	input  wire logic        cmd_rtc_in,
	input  wire logic        cmd_read_in,
	input  wire logic        cmd_set_addr_in,
	input  wire logic [14:0] cmd_addr_in,
	input  wire logic [2:0]  cmd_cs_in,
	input  wire logic [7:0]  cmd_len_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wdata_valid_in,
	output logic             wdata_ready_out,
	output logic [7:0]       rdata_out,
	output logic             rdata_valid_out,
	output logic             done_out,
	output logic             nack_out,
	output logic             busy_out
);
	import twm_pkg::*;

	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BYTE  = 2'h3,
		M_STOP  = 2'h2
	} twm_mst_st_e;

	typedef enum logic [2:0] {
		K_SEL  = 3'h0,
		K_AH   = 3'h1,
		K_AL   = 3'h3,
		K_RSEL = 3'h2,
		K_WD   = 3'h6,
		K_RD   = 3'h7
	} twm_kind_e;

	typedef struct packed {
		twm_mst_st_e st;
		twm_kind_e   kind;
		logic [1:0]  q;
		logic [3:0]  b;
		logic [15:0] div;
		logic [7:0]  sh;
		logic [7:0]  cnt;
		logic [14:0] addr;
		logic        rtc;
		logic        rd;
		logic        set_addr;
		logic [2:0]  cs;
		logic        scl;
		logic        sda_oe_n;
		logic [7:0]  rdata;
		logic        rdata_v;
		logic        done;
		logic        nack;
		logic        sda_s1;
		logic        sda_s2;
	} twm_mst_s;

	twm_mst_s r_q;
	twm_mst_s r_d;

	logic       tick;
	logic       tx;
	logic       stall;
	logic [7:0] txb;

	assign tick            = (r_q.div == 16'(SCL_DIV - 1));
	assign tx              = (r_q.kind != K_RD);
	assign stall           = (r_q.kind == K_WD) & ~wdata_valid_in;
	assign cmd_ready_out   = (r_q.st == M_IDLE);
	assign wdata_ready_out = tick & (r_q.st == M_BYTE) & (r_q.q == 2'h0)
	                       & (r_q.b == 4'h0) & (r_q.kind == K_WD);

	always_comb begin
		unique case (r_q.kind)
			K_SEL:   txb = sel_byte(r_q.rtc, r_q.cs, r_q.rd & ~r_q.set_addr);
			K_AH:    txb = {1'b0, r_q.addr[14:8]};
			K_AL:    txb = r_q.rtc ? {4'h0, r_q.addr[3:0]} : r_q.addr[7:0];
			K_RSEL:  txb = sel_byte(r_q.rtc, r_q.cs, 1'b1);
			K_WD:    txb = wdata_in;
			default: txb = 8'hff;
		endcase
	end

	always_comb begin
		r_d         = r_q;
		r_d.rdata_v = 1'b0;
		r_d.done    = 1'b0;
		r_d.sda_s1  = link_io.sda;
		r_d.sda_s2  = r_q.sda_s1;
		r_d.div     = tick ? 16'h0 : r_q.div + 16'h1;
		if (r_q.st == M_IDLE) begin
			if (cmd_valid_in) begin
				r_d.st       = M_START;
				r_d.kind     = K_SEL;
				r_d.q        = 2'h0;
				r_d.rtc      = cmd_rtc_in;
				r_d.rd       = cmd_read_in;
				r_d.set_addr = cmd_set_addr_in | ~cmd_read_in; // [R20]
				r_d.addr     = cmd_addr_in;
				r_d.cs       = cmd_cs_in;
				r_d.cnt      = (cmd_len_in == 8'h0) ? 8'h1 : cmd_len_in;
				r_d.nack     = 1'b0;
			end
		end else if (tick) begin
			r_d.q = r_q.q + 2'h1;
			unique case (r_q.st)
				M_START: begin
					unique case (r_q.q)
						2'h0: r_d.sda_oe_n = 1'b1;
						2'h1: r_d.scl = 1'b1;
						2'h2: r_d.sda_oe_n = 1'b0;
						2'h3: begin
							r_d.scl = 1'b0;
							r_d.st  = M_BYTE;
							r_d.b   = 4'h0;
						end
					endcase
				end
				M_BYTE: begin
					unique case (r_q.q)
						2'h0: begin
							if (r_q.b == 4'h0 && stall) begin
								r_d.q = r_q.q;
							end else if (r_q.b == 4'h0) begin
								r_d.sh       = txb;
								r_d.sda_oe_n = tx ? txb[7] : 1'b1; // [R12]
							end else if (r_q.b < BITS_DATA) begin
								r_d.sda_oe_n = tx ? r_q.sh[7] : 1'b1;
							end else begin
								// nack on the last read byte ends the read
								r_d.sda_oe_n = tx | (r_q.cnt == 8'h1); // [R17]
							end
						end
						2'h1: r_d.scl = 1'b1;
						2'h2: begin
							if (r_q.b < BITS_DATA && !tx)
								r_d.sh = {r_q.sh[6:0], r_q.sda_s2};
							if (r_q.b == BITS_DATA && tx)
								r_d.nack = r_q.sda_s2;
						end
						2'h3: begin
							r_d.scl = 1'b0;
							if (r_q.b < BITS_DATA) begin
								if (tx)
									r_d.sh = {r_q.sh[6:0], 1'b0};
								r_d.b = r_q.b + 4'h1;
							end else begin
								r_d.b = 4'h0;
								if (tx && r_q.nack) begin
									r_d.st = M_STOP;
								end else begin
									unique case (r_q.kind)
										K_SEL: begin
											if (r_q.set_addr) // [R13]
												r_d.kind = r_q.rtc ? K_AL : K_AH;
											else
												r_d.kind = K_RD;
										end
										K_AH: r_d.kind = K_AL; // [R01]
										K_AL: begin
											if (r_q.rd) begin
												r_d.kind = K_RSEL; // [R18]
												r_d.st   = M_START;
											end else begin
												r_d.kind = K_WD;
											end
										end
										K_RSEL: r_d.kind = K_RD;
										K_WD: begin
											r_d.cnt = r_q.cnt - 8'h1;
											if (r_q.cnt == 8'h1)
												r_d.st = M_STOP;
										end
										K_RD: begin
											r_d.rdata   = r_q.sh;
											r_d.rdata_v = 1'b1;
											r_d.cnt     = r_q.cnt - 8'h1;
											if (r_q.cnt == 8'h1)
												r_d.st = M_STOP;
										end
									endcase
								end
							end
						end
					endcase
				end
				M_STOP: begin
					unique case (r_q.q)
						2'h0: r_d.sda_oe_n = 1'b0;
						2'h1: r_d.scl = 1'b1;
						2'h2: r_d.sda_oe_n = 1'b1;
						2'h3: begin
							r_d.st   = M_IDLE;
							r_d.done = 1'b1;
						end
					endcase
				end
				default: r_d.st = M_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_q          <= '0;
			r_q.scl      <= 1'b1;
			r_q.sda_oe_n <= 1'b1;
			r_q.sda_s1   <= 1'b1;
			r_q.sda_s2   <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign link_io.scl          = r_q.scl;
	assign link_io.mst_sda_out  = 1'b0;
	assign link_io.mst_sda_oe_n = r_q.sda_oe_n;
	assign rdata_out            = r_q.rdata;
	assign rdata_valid_out      = r_q.rdata_v;
	assign done_out             = r_q.done;
	assign nack_out             = r_q.nack;
	assign busy_out             = (r_q.st != M_IDLE);
endmodule : twm_mst
`default_nettype wire

/* twm_dev.sv */
// two-wire device end: memory and clock-register access slave
// What this block does
// [R01] memory write takes two address bytes, high first
// [R02] memory latch is 15 bits, top bit ignored
// [R03] latch increments after each byte, before acknowledge
// [R04] memory latch wraps 7fff to 0000
// [R05] memory and clock latches kept separate
// [R06] memory latch changes only by load or increment
// [R07] no limit on bytes per transaction
// [R08] clock address uses low four bits only
// [R09] master loads clock addresses zero to eight only; twm_mst sends any of 0 to 15
// [R10] read: eight bits out, then sample master acknowledge
// [R11] write: eight bits in, then drive acknowledge
// [R12] all bytes travel most significant bit first
// [R13] master writes with read/write bit zero
// [R14] memory written at eighth bit, before acknowledge
// [R15] master aborts write by start or stop early
// [R16] read selection starts data on next clock
// [R17] master ends read by nack or start/stop
// [R18] selective read keeps newly latched address
// [R19] clock latch auto-increments like memory latch
// [R20] every write carries an address phase
// [R21] ids 1010 memory, 1101 clock; bit0 read
// [R22] selection bits three to one match chip pins
// [R23] both latches start at zero
`timescale 1ns/10ps
`default_nettype none
module twm_dev (
	input  wire logic        link_clk_in,
	input  wire logic        rst_n_in,
	twm_link_if.dev          link_io,
	input  wire logic [2:0]  chip_select_pins_in,
	input  wire logic [7:0]  rtc_rdata_in,
	output logic [3:0]       rtc_addr_out,
	output logic             rtc_wr_out,
	output logic [7:0]       rtc_wdata_out,
	output logic [14:0]      mem_addr_out,
	output logic             busy_out
);
	import twm_pkg::*;

	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_SEL  = 3'h1,
		D_AH   = 3'h3,
		D_AL   = 3'h2,
		D_WR   = 3'h6,
		D_RD   = 3'h7
	} twm_dev_st_e;

	typedef struct packed {
		twm_dev_st_e st;
		twm_dev_st_e nxt;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [6:0]  hi;
		logic        rtc;
		logic        ack;
		logic [14:0] mem_addr;
		logic [3:0]  rtc_ptr;
		logic        rtc_wr;
		logic [7:0]  wd;
		logic        sda_oe_n;
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_p;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_p;
		logic [2:0]  cs_s1;
		logic [2:0]  cs_s2;
	} twm_dev_s;

	twm_dev_s r_q;
	twm_dev_s r_d;

	logic [7:0]  mem [MEM_WORDS];
	logic        mem_we;
	logic [14:0] mem_wa;
	logic [7:0]  mem_wd;

	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic [7:0] byte_in;
	logic [7:0] rd_src;
	logic       match;

	// 15-bit increment rolls over naturally at the top location
	function automatic logic [14:0] inc_mem(input logic [14:0] a);
		inc_mem = a + 15'h1; // [R04]
	endfunction : inc_mem

	function automatic logic [3:0] inc_rtc(input logic [3:0] a);
		inc_rtc = a + 4'h1; // [R19]
	endfunction : inc_rtc

	assign rise    = r_q.scl_s2 & ~r_q.scl_p;
	assign fall    = ~r_q.scl_s2 & r_q.scl_p;
	assign start_c = r_q.scl_s2 & r_q.scl_p & r_q.sda_p & ~r_q.sda_s2;
	assign stop_c  = r_q.scl_s2 & r_q.scl_p & ~r_q.sda_p & r_q.sda_s2;
	assign byte_in = {r_q.sh[6:0], r_q.sda_s2}; // [R12]
	assign rd_src  = r_q.rtc ? rtc_rdata_in : mem[r_q.mem_addr];
	assign match   = ((byte_in[SEL_ID_MSB:SEL_ID_LSB] == MEM_ID)
	               || (byte_in[SEL_ID_MSB:SEL_ID_LSB] == RTC_ID)) // [R21]
	               && (byte_in[SEL_CS_MSB:SEL_CS_LSB] == r_q.cs_s2); // [R22]

	always_comb begin
		r_d        = r_q;
		r_d.rtc_wr = 1'b0;
		mem_we     = 1'b0;
		mem_wa     = r_q.mem_addr;
		mem_wd     = byte_in;
		r_d.scl_s1 = link_io.scl;
		r_d.scl_s2 = r_q.scl_s1;
		r_d.scl_p  = r_q.scl_s2;
		r_d.sda_s1 = link_io.sda;
		r_d.sda_s2 = r_q.sda_s1;
		r_d.sda_p  = r_q.sda_s2;
		r_d.cs_s1  = chip_select_pins_in;
		r_d.cs_s2  = r_q.cs_s1;
		if (start_c) begin
			// repeated start drops any write but leaves both latches
			r_d.st       = D_SEL; // [R18]
			r_d.cnt      = 4'h0;
			r_d.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			r_d.st       = D_IDLE;
			r_d.sda_oe_n = 1'b1;
		end else begin
			unique case (r_q.st)
				D_IDLE: r_d.cnt = 4'h0;
				D_RD: begin
					if (rise) begin
						r_d.cnt = r_q.cnt + 4'h1;
						if (r_q.cnt == BITS_DATA - 4'h1) begin
							if (r_q.rtc)
								r_d.rtc_ptr = inc_rtc(r_q.rtc_ptr); // [R19] [R05]
							else
								r_d.mem_addr = inc_mem(r_q.mem_addr); // [R03] [R06]
						end
						if (r_q.cnt == BITS_DATA)
							r_d.ack = ~r_q.sda_s2; // [R10]
					end else if (fall) begin
						if (r_q.cnt < BITS_DATA) begin
							r_d.sh       = {r_q.sh[6:0], 1'b0};
							r_d.sda_oe_n = r_q.sh[6]; // [R12]
						end else if (r_q.cnt == BITS_DATA) begin
							r_d.sda_oe_n = 1'b1;
						end else if (r_q.ack) begin
							r_d.sh       = rd_src; // [R07]
							r_d.sda_oe_n = rd_src[7];
							r_d.cnt      = 4'h0;
						end else begin
							r_d.st = D_IDLE; // [R10]
						end
					end
				end
				default: begin
					if (rise && r_q.cnt < BITS_DATA) begin
						r_d.sh  = byte_in;
						r_d.cnt = r_q.cnt + 4'h1;
						if (r_q.cnt == BITS_DATA - 4'h1) begin
							r_d.ack = 1'b1;
							unique case (r_q.st)
								D_SEL: begin
									r_d.ack = match;
									r_d.rtc = (byte_in[SEL_ID_MSB:SEL_ID_LSB]
									        == RTC_ID);
									if (!match)
										r_d.nxt = D_IDLE;
									else if (byte_in[SEL_RW_BIT])
										r_d.nxt = D_RD;
									else if (byte_in[SEL_ID_MSB:SEL_ID_LSB]
									         == RTC_ID)
										r_d.nxt = D_AL;
									else
										r_d.nxt = D_AH;
								end
								D_AH: begin
									r_d.hi  = byte_in[6:0]; // [R02]
									r_d.nxt = D_AL;
								end
								D_AL: begin
									if (r_q.rtc)
										r_d.rtc_ptr = byte_in[3:0]; // [R08]
									else
										r_d.mem_addr = {r_q.hi, byte_in}; // [R01]
									r_d.nxt = D_WR;
								end
								D_WR: begin
									r_d.nxt = D_WR; // [R07]
									if (r_q.rtc) begin
										r_d.rtc_wr  = 1'b1;
										r_d.wd      = byte_in;
										r_d.rtc_ptr = inc_rtc(r_q.rtc_ptr); // [R03]
									end else begin
										mem_we       = 1'b1; // [R14]
										r_d.mem_addr = inc_mem(r_q.mem_addr); // [R03]
									end
								end
								default: r_d.nxt = D_IDLE;
							endcase
						end
					end else if (rise) begin
						r_d.cnt = BIT_ACK;
					end else if (fall && r_q.cnt == BITS_DATA) begin
						r_d.sda_oe_n = ~r_q.ack; // [R11]
					end else if (fall && r_q.cnt == BIT_ACK) begin
						r_d.sda_oe_n = 1'b1;
						r_d.cnt      = 4'h0;
						r_d.st       = r_q.nxt;
						if (r_q.nxt == D_RD) begin
							// first read bit follows the selection ack
							r_d.sh       = rd_src; // [R16]
							r_d.sda_oe_n = rd_src[7];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r_q          <= '0;
			r_q.mem_addr <= MEM_ADDR_RST; // [R23]
			r_q.rtc_ptr  <= RTC_ADDR_RST; // [R23]
			r_q.sda_oe_n <= 1'b1;
			r_q.scl_s1   <= 1'b1;
			r_q.scl_s2   <= 1'b1;
			r_q.scl_p    <= 1'b1;
			r_q.sda_s1   <= 1'b1;
			r_q.sda_s2   <= 1'b1;
			r_q.sda_p    <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// storage array, no reset
	always_ff @(posedge link_clk_in) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd; // [R14]
	end

	assign link_io.dev_sda_out  = 1'b0;
	assign link_io.dev_sda_oe_n = r_q.sda_oe_n;
	assign rtc_addr_out         = r_q.rtc_ptr;
	assign rtc_wr_out           = r_q.rtc_wr;
	assign rtc_wdata_out        = r_q.wd;
	assign mem_addr_out         = r_q.mem_addr;
	assign busy_out             = (r_q.st != D_IDLE);
endmodule : twm_dev
`default_nettype wire

/* twm_link_properties.sv */
// link-level timing and address latch checks for the two-wire ends
`timescale 1ns/10ps
`default_nettype none
module twm_link_properties (
	input wire logic        mclk_in,
	input wire logic        link_clk_in,
	input wire logic        rst_n_in,
	input wire logic        scl,
	input wire logic        dev_sda_oe_n,
	input wire logic [14:0] mem_addr_out,
	input wire logic [3:0]  rtc_addr_out,
	input wire logic        rtc_wr_out
);
	sequence s_top_step;
		mem_addr_out == 15'h7fff ##1 $changed(mem_addr_out);
	endsequence

	sequence s_rtc_store;
		rtc_wr_out ##0 scl;
	endsequence

	a_dev_drive_low: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) $changed(dev_sda_oe_n) |-> !scl && !$past(scl))
		else $error("device data line moved while clock high");
	a_mem_wrap_zero: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) s_top_step |-> mem_addr_out == 15'h0000)
		else $error("memory latch did not wrap to zero");
	a_mem_scl_high: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) $changed(mem_addr_out) |-> scl && $past(scl))
		else $error("memory latch moved outside a bit sample");
	a_latch_apart: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) $changed(mem_addr_out) |-> $stable(rtc_addr_out))
		else $error("both latches moved together");
	a_rtc_wr_step: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in)
		s_rtc_store |-> rtc_addr_out == $past(rtc_addr_out) + 4'h1)
		else $error("clock latch did not step with the write");
	a_rtc_wr_single: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) rtc_wr_out |=> !rtc_wr_out [*3])
		else $error("clock register write pulse too long");
	a_rtc_scl_high: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) $changed(rtc_addr_out) |-> scl)
		else $error("clock latch moved while clock low");
	a_scl_high_hold: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in) $rose(scl) |=> scl [*4])
		else $error("bus clock high phase too short");
endmodule : twm_link_properties
`default_nettype wire

/* two_wire_mem_rtc_access_bench.sv */
// self-checking bench for both ends of the two-wire link
`timescale 1ns/10ps
`default_nettype none
module two_wire_mem_rtc_access_bench;
	import twm_pkg::*;
	localparam logic [2:0] PINS = 3'h5;
	logic [2:0]  pins = PINS;
	logic        mclk = 1'b0;
	logic        lclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_rtc = 1'b0;
	logic        cmd_read = 1'b0;
	logic        cmd_set = 1'b0;
	logic        wvalid = 1'b1;
	logic [14:0] cmd_addr = 15'h0000;
	logic [2:0]  cmd_cs = 3'h0;
	logic [7:0]  cmd_len = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic        cmd_ready, wready, rvalid, done, nack, mbusy, dbusy, rtc_wr;
	logic [7:0]  rdata, rtc_wdata;
	wire  [7:0]  rtc_rdata;
	logic [14:0] mem_addr, mptr;
	logic [3:0]  rtc_addr;
	logic [7:0]  mem_m [32768];
	logic [7:0]  regs [16];
	logic [7:0]  wq[$];
	logic [7:0]  rq[$];
	logic [31:0] seed = 32'h9024;
	int          errors = 0;
	int          compares = 0;

	always #25 mclk = ~mclk;
	always #6 lclk = ~lclk;

	twm_link_if link_i ();
	twm_mst twm_mst_i (.mclk_in(mclk), .rst_n_in(rst_n), .link_io(link_i.mst),
		.cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_rtc_in(cmd_rtc), .cmd_read_in(cmd_read),
		.cmd_set_addr_in(cmd_set), .cmd_addr_in(cmd_addr),
		.cmd_cs_in(cmd_cs), .cmd_len_in(cmd_len), .wdata_in(wdata),
		.wdata_valid_in(wvalid), .wdata_ready_out(wready),
		.rdata_out(rdata), .rdata_valid_out(rvalid), .done_out(done),
		.nack_out(nack), .busy_out(mbusy));
	twm_dev twm_dev_i (.link_clk_in(lclk), .rst_n_in(rst_n),
		.link_io(link_i.dev), .chip_select_pins_in(pins),
		.rtc_rdata_in(rtc_rdata), .rtc_addr_out(rtc_addr),
		.rtc_wr_out(rtc_wr), .rtc_wdata_out(rtc_wdata),
		.mem_addr_out(mem_addr), .busy_out(dbusy));
	twm_link_properties twm_link_properties_i (.mclk_in(mclk),
		.link_clk_in(lclk), .rst_n_in(rst_n), .scl(link_i.scl),
		.dev_sda_oe_n(link_i.dev_sda_oe_n), .mem_addr_out(mem_addr),
		.rtc_addr_out(rtc_addr), .rtc_wr_out(rtc_wr));

	// clock register file answering the device end
	assign rtc_rdata = regs[rtc_addr];
	always @(posedge lclk) begin
		if (rtc_wr === 1'b1) regs[rtc_addr - 4'h1] <= rtc_wdata;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [14:0] nxt(input logic [14:0] a, input int n);
		return a + 15'(n);
	endfunction : nxt

	task automatic chk(input string what, input logic [31:0] exp,
	                   input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_sim();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic xfer(input logic rtc, rd, set, input logic [14:0] a,
	                    input logic [2:0] cs, input int n);
		int i;
		int k;
		i = 0;
		k = 0;
		rq = {};
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_rtc <= rtc;
		cmd_read <= rd;
		cmd_set <= set;
		cmd_addr <= a;
		cmd_cs <= cs;
		cmd_len <= 8'(n);
		wdata <= (wq.size() > 0) ? wq[0] : 8'h00;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge mclk);
			if (rvalid === 1'b1) rq.push_back(rdata);
			if (wready === 1'b1) begin
				if (wvalid) i++;
				@(posedge mclk);
				wdata <= (i < wq.size()) ? wq[i] : 8'h00;
				// random stalls before the next write byte
				wvalid <= ~wvalid | ^rnd();
			end
			k++;
		end while (done !== 1'b1 && k < 40000);
		if (done !== 1'b1) begin
			errors++;
			end_sim();
		end
		chk("nack", 32'(cs != pins), 32'(nack));
		chk("master busy", 32'h0, 32'(mbusy));
		chk("dev busy", 32'h0, 32'(dbusy));
		chk("ready", 32'h1, 32'(cmd_ready));
	endtask : xfer

	task automatic mw(input logic [14:0] a, input int n);
		wq = {};
		for (int j = 0; j < n; j++) begin
			wq.push_back(8'(rnd()));
			mem_m[nxt(a, j)] = wq[j];
		end
		xfer(1'b0, 1'b0, 1'b1, a, PINS, n);
		mptr = nxt(a, n);
		chk("mem latch", 32'(mptr), 32'(mem_addr));
	endtask : mw

	task automatic mr(input logic set, input logic [14:0] a, input int n);
		if (set) mptr = a;
		xfer(1'b0, 1'b1, set, a, PINS, n);
		for (int j = 0; j < n; j++)
			chk("mem byte", 32'(mem_m[nxt(mptr, j)]), 32'(rq[j]));
		mptr = nxt(mptr, n);
		chk("mem latch", 32'(mptr), 32'(mem_addr));
	endtask : mr

	initial begin
		logic [14:0] a;
		for (int j = 0; j < 16; j++) regs[j] = 8'(rnd());
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("mem latch", 32'h0, 32'(mem_addr));
		chk("rtc latch", 32'h0, 32'(rtc_addr));
		mw(15'h7ffe, 4);
		mr(1'b1, 15'h7ffe, 4);
		$display("test wrap done");
		a = 15'(rnd());
		mw(a, 12);
		mr(1'b1, a, 2);
		mr(1'b0, a, 3);
		wq = {8'(rnd()), 8'(rnd()), 8'(rnd())};
		xfer(1'b1, 1'b0, 1'b1, 15'h0003, PINS, 3);
		for (int j = 0; j < 3; j++)
			chk("rtc reg", 32'(wq[j]), 32'(regs[3 + j]));
		chk("rtc latch", 32'h6, 32'(rtc_addr));
		chk("mem latch", 32'(mptr), 32'(mem_addr));
		xfer(1'b1, 1'b1, 1'b1, 15'h0002, PINS, 4);
		for (int j = 0; j < 4; j++)
			chk("rtc byte", 32'(regs[2 + j]), 32'(rq[j]));
		xfer(1'b1, 1'b1, 1'b0, 15'h0000, PINS, 2);
		for (int j = 0; j < 2; j++)
			chk("rtc byte", 32'(regs[6 + j]), 32'(rq[j]));
		chk("rtc latch", 32'h8, 32'(rtc_addr));
		mr(1'b0, a, 3);
		$display("test clock registers done");
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk);
			// odd selections match the pins, even ones never do
			pins <= c[0] ? 3'(c) : 3'(c + 1 + int'(rnd() % 7));
			xfer(1'b0, 1'b1, 1'b0, 15'h0000, 3'(c), 1);
			chk("nack", 32'(3'(c) != pins), 32'(nack));
			if (3'(c) == pins) begin
				chk("mem byte", 32'(mem_m[mptr]), 32'(rq[0]));
				mptr = nxt(mptr, 1);
			end
		end
		@(posedge mclk);
		pins <= PINS;
		chk("mem latch", 32'(mptr), 32'(mem_addr));
		$display("test select pins done");
		for (int t = 0; t < 4; t++) begin
			a = 15'(rnd());
			mw(a, 1 + int'(rnd() % 8));
			mr(1'b1, a, wq.size());
		end
		$display("test random done");
		end_sim();
	end
endmodule : two_wire_mem_rtc_access_bench
`default_nettype wire
